/* File: verilog/cps_pkg.sv */
`default_nettype none
package cps_pkg;

    // ------------
    // timing
    // ------------
    localparam int unsigned CPS_CLK_PERIOD_NS   = 10;
    localparam int unsigned CPS_RAMP_TIMEOUT_US = 100000;
    localparam int unsigned CPS_RAMP_CYCLES     =
        CPS_RAMP_TIMEOUT_US * 1000 / CPS_CLK_PERIOD_NS;
    localparam int          CPS_RAMP_CNT_W      = 27;

    // ------------
    // widths
    // ------------
    localparam int CPS_SPARE_W = 8;
    localparam int CPS_EQ_W    = 13;
    localparam int CPS_LED_W   = 3;
    localparam int CPS_PROBE_W = 2;
    localparam int CPS_NUM_PHY = 2;
    localparam int CPS_IRQ_W   = 8;
    localparam int CPS_MEZZ_W  = 7;
    localparam int CPS_PHY_IN_W = 9 * CPS_NUM_PHY;

    // ------------
    // register offsets
    // ------------
    localparam logic [7:0] CPS_OFS_CTRL       = 8'h00;
    localparam logic [7:0] CPS_OFS_STATUS     = 8'h04;
    localparam logic [7:0] CPS_OFS_SPARE_OUT  = 8'h08;
    localparam logic [7:0] CPS_OFS_FANOUT_EQ  = 8'h0C;
    localparam logic [7:0] CPS_OFS_LED        = 8'h10;
    localparam logic [7:0] CPS_OFS_PROBE      = 8'h14;
    localparam logic [7:0] CPS_OFS_PHY_IN     = 8'h18;
    localparam logic [7:0] CPS_OFS_IRQ_STATUS = 8'h1C;
    localparam logic [7:0] CPS_OFS_IRQ_ENABLE = 8'h20;
    localparam logic [7:0] CPS_OFS_IRQ_CLEAR  = 8'h24;

    // ------------
    // control fields
    // ------------
    localparam int CPS_CTRL_PWR_EN    = 0;
    localparam int CPS_CTRL_SPARE_EN  = 1;
    localparam int CPS_CTRL_ALERT_TRIP = 2;

    // ------------
    // synchronised mezzanine/board input vector positions
    // ------------
    localparam int CPS_IN_PRESENT_N   = 0;
    localparam int CPS_IN_SUPPLIES_OK = 1;
    localparam int CPS_IN_READY       = 2;
    localparam int CPS_IN_SPARE_CTRL  = 3;
    localparam int CPS_IN_MEZZ_ALERT_N = 4;
    localparam int CPS_IN_BOARD_ALERT_N = 5;
    localparam int CPS_IN_BOARD_PWR_OK = 6;

    // ------------
    // status register fields beyond the input vector
    // ------------
    localparam int CPS_ST_POWER_ALLOW = 8;
    localparam int CPS_ST_SPARE_DRIVEN = 9;
    localparam int CPS_ST_STATE_LSB   = 12;

    // ------------
    // interrupt event positions
    // ------------
    localparam int CPS_EV_PRESENT_CHG   = 0;
    localparam int CPS_EV_SUPPLIES_FELL = 1;
    localparam int CPS_EV_READY_ROSE    = 2;
    localparam int CPS_EV_MEZZ_ALERT    = 3;
    localparam int CPS_EV_BOARD_ALERT   = 4;
    localparam int CPS_EV_BOARD_PWR_FELL = 5;
    localparam int CPS_EV_RAMP_TIMEOUT  = 6;
    localparam int CPS_EV_PHY_INT       = 7;

    // ------------
    // reset values
    // ------------
    localparam logic [CPS_MEZZ_W-1:0]   CPS_RST_MEZZ_IN = 7'h79;
    localparam logic [CPS_PHY_IN_W-1:0] CPS_RST_PHY_IN  = 18'h3FFFF;
    localparam logic [2:0]              CPS_RST_CTRL    = 3'h0;
    localparam logic [CPS_SPARE_W-1:0]  CPS_RST_SPARE   = 8'h00;
    localparam logic [CPS_EQ_W-1:0]     CPS_RST_EQ      = 13'h1FFF;
    localparam logic [CPS_LED_W-1:0]    CPS_RST_LED     = 3'h0;
    localparam logic [CPS_PROBE_W-1:0]  CPS_RST_PROBE   = 2'h0;

    typedef enum logic [1:0] {
        CPS_PWR_OFF,
        CPS_PWR_RAMP,
        CPS_PWR_ON,
        CPS_PWR_FAULT
    } cps_pwr_state_type;

endpackage
`default_nettype wire

/* File: verilog/cps_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module cps_sync
#(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    // ----------------------------------------------------------------
    // two flops per bit, first stage feeds only the second
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    meta_r <= RST_VAL[g];
                    sync_r <= RST_VAL[g];
                end
                else
                begin
                    meta_r <= d_i[g];
                    sync_r <= meta_r;
                end
            end
            assign q_o[g] = sync_r;
        end
    endgenerate

endmodule // cps_sync
`default_nettype wire

/* File: verilog/cps_irq.sv */
`timescale 1ns/1ns
`default_nettype none
module cps_irq
    import cps_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic [CPS_IRQ_W-1:0] event_i,
    input  wire logic                 enable_wr_i,
    input  wire logic                 clear_wr_i,
    input  wire logic [CPS_IRQ_W-1:0] wdata_i,
    output logic      [CPS_IRQ_W-1:0] status_o,
    output logic      [CPS_IRQ_W-1:0] enable_o,
    output logic                      irq_o
);

    logic [CPS_IRQ_W-1:0] status_r;
    logic [CPS_IRQ_W-1:0] enable_r;

    // ----------------------------------------------------------------
    // sticky status, a new event wins over a clear in the same cycle
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            status_r <= '0;
        else if (clear_wr_i)
            status_r <= (status_r & ~wdata_i) | event_i;
        else
            status_r <= status_r | event_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            enable_r <= '0;
        else if (enable_wr_i)
            enable_r <= wdata_i;
    end

    assign status_o = status_r;
    assign enable_o = enable_r;
    assign irq_o    = |(status_r & enable_r);

endmodule // cps_irq
`default_nettype wire

/* File: verilog/cps_top.sv */
// Function
// R1: eight single-ended spare outputs, carrier drives
// R2: spare lines high impedance until mezz_supplies_ok
// R3: mezz_supplies_ok high only with all mezzanine supplies good
// R4: mezz_ready high only when mezzanine is ready
// R5: mezz_present_n is active low
// R6: power permission is the pair mezz_power_allow, mezz_power_allow_n
// R7: locked off: mezz_power_allow low, mezz_power_allow_n high
// R8: mezz_supply_alert_n low flags mezzanine supply problem
// R9: board_supply_alert_n low flags a converter needing attention
// R10: board_power_ok low flags a board supply fault
// R11: thirteen fanout_eq_enable outputs, high by default
// R12: fanout_eq_enable bits software controllable
// R13: three panel_led_out outputs, low by default
// R14: two scope_probe_out outputs, low unless used
// R15: PHY outputs held low
// R16: PHY-driven lines only received
// R17: mezz_spare_ctrl spare input, reads high undriven
// R18: power off from reset, granted while present and enabled; code holds it off in FAULT after a ramp timeout or alert trip
// R19: asynchronous inputs pass a two-stage synchroniser
`timescale 1ns/1ns
`default_nettype none
module cps_top
    import cps_pkg::*;
#(
    parameter int unsigned RAMP_CYCLES = CPS_RAMP_CYCLES
)
(
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    // register port
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [31:0]            reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [31:0]            reg_rdata_o,
    output logic                        irq_o,
    // mezzanine
    input  wire logic                   mezz_present_n_i,
    input  wire logic                   mezz_supplies_ok_i,
    input  wire logic                   mezz_ready_i,
    input  wire logic                   mezz_spare_ctrl_i,
    input  wire logic                   mezz_supply_alert_n_i,
    output logic                        mezz_power_allow_o,
    output logic                        mezz_power_allow_n_o,
    output logic      [CPS_SPARE_W-1:0] spare_link_o,
    output logic      [CPS_SPARE_W-1:0] spare_link_oe_o,
    // board
    input  wire logic                   board_supply_alert_n_i,
    input  wire logic                   board_power_ok_i,
    output logic      [CPS_EQ_W-1:0]    fanout_eq_enable_o,
    output logic      [CPS_LED_W-1:0]   panel_led_out_o,
    output logic      [CPS_PROBE_W-1:0] scope_probe_out_o,
    // ethernet phys
    output logic      [4*CPS_NUM_PHY-1:0] phy_txd_o,
    output logic      [CPS_NUM_PHY-1:0] phy_tx_en_o,
    output logic      [CPS_NUM_PHY-1:0] phy_gtx_clk_o,
    output logic      [CPS_NUM_PHY-1:0] phy_mdc_o,
    output logic      [CPS_NUM_PHY-1:0] phy_mdio_o,
    output logic      [CPS_NUM_PHY-1:0] phy_mdio_oe_o,
    input  wire logic [4*CPS_NUM_PHY-1:0] phy_rxd_i,
    input  wire logic [CPS_NUM_PHY-1:0] phy_rx_clk_i,
    input  wire logic [CPS_NUM_PHY-1:0] phy_rx_dv_i,
    input  wire logic [CPS_NUM_PHY-1:0] phy_clk125_i,
    input  wire logic [CPS_NUM_PHY-1:0] phy_mdio_i,
    input  wire logic [CPS_NUM_PHY-1:0] phy_int_n_i
);

    // ------------
    // declarations
    // ------------
    logic [CPS_MEZZ_W-1:0]   mezz_raw;
    logic [CPS_MEZZ_W-1:0]   mezz_s;
    logic [CPS_MEZZ_W-1:0]   mezz_d_r;
    logic [CPS_PHY_IN_W-1:0] phy_raw;
    logic [CPS_PHY_IN_W-1:0] phy_s;
    logic [CPS_NUM_PHY-1:0]  phy_int_d_r;

    logic present;
    logic supplies_ok;
    logic ready;
    logic mezz_alert;
    logic board_alert;
    logic board_pwr_ok;

    logic [2:0]             ctrl_r;
    logic [CPS_SPARE_W-1:0] spare_r;
    logic [CPS_EQ_W-1:0]    eq_r;
    logic [CPS_LED_W-1:0]   led_r;
    logic [CPS_PROBE_W-1:0] probe_r;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;

    cps_pwr_state_type state_r;
    cps_pwr_state_type state_nxt;
    logic [CPS_RAMP_CNT_W-1:0] ramp_cnt_r;
    logic ramp_timeout;
    logic allow_r;
    logic spare_oe_r;
    logic grant_ok;
    logic trip;

    logic [CPS_IRQ_W-1:0] events;
    logic [CPS_IRQ_W-1:0] irq_status;
    logic [CPS_IRQ_W-1:0] irq_enable;
    logic                 irq;
    logic [31:0]          status_word;

    // ------------
    // input synchronisers
    // ------------
    assign mezz_raw = {board_power_ok_i,
                       board_supply_alert_n_i,
                       mezz_supply_alert_n_i,
                       mezz_spare_ctrl_i,
                       mezz_ready_i,
                       mezz_supplies_ok_i,
                       mezz_present_n_i};

    assign phy_raw = {phy_int_n_i,
                      phy_mdio_i,
                      phy_clk125_i,
                      phy_rx_dv_i,
                      phy_rx_clk_i,
                      phy_rxd_i}; // R16

    cps_sync
    #(
        .W       (CPS_MEZZ_W),
        .RST_VAL (CPS_RST_MEZZ_IN)
    )
    u_sync_mezz
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (mezz_raw),
        .q_o     (mezz_s)
    ); // R19

    cps_sync
    #(
        .W       (CPS_PHY_IN_W),
        .RST_VAL (CPS_RST_PHY_IN)
    )
    u_sync_phy
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (phy_raw),
        .q_o     (phy_s)
    ); // R19

    assign present      = ~mezz_s[CPS_IN_PRESENT_N]; // R5
    assign supplies_ok  = mezz_s[CPS_IN_SUPPLIES_OK];
    assign ready        = mezz_s[CPS_IN_READY];
    assign mezz_alert   = ~mezz_s[CPS_IN_MEZZ_ALERT_N]; // R8
    assign board_alert  = ~mezz_s[CPS_IN_BOARD_ALERT_N]; // R9
    assign board_pwr_ok = mezz_s[CPS_IN_BOARD_PWR_OK]; // R10

    // ------------
    // edge history for event detection
    // ------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mezz_d_r    <= CPS_RST_MEZZ_IN;
            phy_int_d_r <= '1;
        end
        else
        begin
            mezz_d_r    <= mezz_s;
            phy_int_d_r <= phy_s[CPS_PHY_IN_W-1 -: CPS_NUM_PHY];
        end
    end

    // ------------
    // register writes
    // ------------
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ctrl_r <= CPS_RST_CTRL; // R18
        else if (reg_wr_i && reg_addr_i == CPS_OFS_CTRL)
            ctrl_r <= reg_wdata_i[2:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            spare_r <= CPS_RST_SPARE;
        else if (reg_wr_i && reg_addr_i == CPS_OFS_SPARE_OUT)
            spare_r <= reg_wdata_i[CPS_SPARE_W-1:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            eq_r <= CPS_RST_EQ; // R11
        else if (reg_wr_i && reg_addr_i == CPS_OFS_FANOUT_EQ)
            eq_r <= reg_wdata_i[CPS_EQ_W-1:0]; // R12
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            led_r <= CPS_RST_LED; // R13
        else if (reg_wr_i && reg_addr_i == CPS_OFS_LED)
            led_r <= reg_wdata_i[CPS_LED_W-1:0];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            probe_r <= CPS_RST_PROBE; // R14
        else if (reg_wr_i && reg_addr_i == CPS_OFS_PROBE)
            probe_r <= reg_wdata_i[CPS_PROBE_W-1:0];
    end

    // ------------
    // power sequencer
    // ------------
    assign grant_ok     = ctrl_r[CPS_CTRL_PWR_EN] && present; // R18
    assign trip         = ctrl_r[CPS_CTRL_ALERT_TRIP] && mezz_alert;
    assign ramp_timeout = (state_r == CPS_PWR_RAMP) && !supplies_ok
                          && (ramp_cnt_r == CPS_RAMP_CNT_W'(RAMP_CYCLES - 1));

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            CPS_PWR_OFF:
            begin
                if (grant_ok)
                    state_nxt = CPS_PWR_RAMP;
            end
            CPS_PWR_RAMP:
            begin
                if (!grant_ok)
                    state_nxt = CPS_PWR_OFF; // R18
                else if (trip || ramp_timeout)
                    state_nxt = CPS_PWR_FAULT;
                else if (supplies_ok)
                    state_nxt = CPS_PWR_ON;
            end
            CPS_PWR_ON:
            begin
                if (!grant_ok)
                    state_nxt = CPS_PWR_OFF; // R18
                else if (trip)
                    state_nxt = CPS_PWR_FAULT;
                else if (!supplies_ok)
                    state_nxt = CPS_PWR_RAMP; // R18
            end
            CPS_PWR_FAULT:
            begin
                // held off until software drops the enable
                if (!ctrl_r[CPS_CTRL_PWR_EN])
                    state_nxt = CPS_PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_r <= CPS_PWR_OFF; // R18
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ramp_cnt_r <= '0;
        else if (state_r != CPS_PWR_RAMP)
            ramp_cnt_r <= '0;
        else if (!ramp_timeout)
            ramp_cnt_r <= ramp_cnt_r + CPS_RAMP_CNT_W'(1);
    end

    // registered pin drive: allow pair and spare enables
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            allow_r    <= 1'b0; // R7
            spare_oe_r <= 1'b0; // R2
        end
        else
        begin
            allow_r    <= (state_nxt == CPS_PWR_RAMP) || (state_nxt == CPS_PWR_ON); // R6
            spare_oe_r <= (state_nxt == CPS_PWR_ON) && ctrl_r[CPS_CTRL_SPARE_EN]; // R2
        end
    end

    // ------------
    // interrupts
    // ------------
    assign events[CPS_EV_PRESENT_CHG]   = mezz_s[CPS_IN_PRESENT_N] ^ mezz_d_r[CPS_IN_PRESENT_N];
    assign events[CPS_EV_SUPPLIES_FELL] = !supplies_ok && mezz_d_r[CPS_IN_SUPPLIES_OK];
    assign events[CPS_EV_READY_ROSE]    = ready && !mezz_d_r[CPS_IN_READY];
    assign events[CPS_EV_MEZZ_ALERT]    = mezz_alert && mezz_d_r[CPS_IN_MEZZ_ALERT_N]; // R8
    assign events[CPS_EV_BOARD_ALERT]   = board_alert && mezz_d_r[CPS_IN_BOARD_ALERT_N]; // R9
    assign events[CPS_EV_BOARD_PWR_FELL] = !board_pwr_ok && mezz_d_r[CPS_IN_BOARD_PWR_OK]; // R10
    assign events[CPS_EV_RAMP_TIMEOUT]  = ramp_timeout;
    assign events[CPS_EV_PHY_INT]       =
        |(~phy_s[CPS_PHY_IN_W-1 -: CPS_NUM_PHY] & phy_int_d_r);

    cps_irq u_irq
    (
        .clk_i       (clk_i),
        .rst_b_i     (rst_b_i),
        .event_i     (events),
        .enable_wr_i (reg_wr_i && reg_addr_i == CPS_OFS_IRQ_ENABLE),
        .clear_wr_i  (reg_wr_i && reg_addr_i == CPS_OFS_IRQ_CLEAR),
        .wdata_i     (reg_wdata_i[CPS_IRQ_W-1:0]),
        .status_o    (irq_status),
        .enable_o    (irq_enable),
        .irq_o       (irq)
    );

    // ------------
    // register reads
    // ------------
    always_comb
    begin
        status_word                         = '0;
        status_word[CPS_MEZZ_W-1:0]         = mezz_s;
        status_word[CPS_IN_PRESENT_N]       = present; // R5
        status_word[CPS_IN_SPARE_CTRL]      = mezz_s[CPS_IN_SPARE_CTRL]; // R17
        status_word[CPS_IN_MEZZ_ALERT_N]    = mezz_alert;
        status_word[CPS_IN_BOARD_ALERT_N]   = board_alert;
        status_word[CPS_ST_POWER_ALLOW]     = allow_r;
        status_word[CPS_ST_SPARE_DRIVEN]    = spare_oe_r;
        status_word[CPS_ST_STATE_LSB +: 2]  = state_r;
    end

    always_comb
    begin
        rdata_nxt = '0;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                CPS_OFS_CTRL:       rdata_nxt[2:0] = ctrl_r;
                CPS_OFS_STATUS:     rdata_nxt = status_word;
                CPS_OFS_SPARE_OUT:  rdata_nxt[CPS_SPARE_W-1:0] = spare_r;
                CPS_OFS_FANOUT_EQ:  rdata_nxt[CPS_EQ_W-1:0] = eq_r;
                CPS_OFS_LED:        rdata_nxt[CPS_LED_W-1:0] = led_r;
                CPS_OFS_PROBE:      rdata_nxt[CPS_PROBE_W-1:0] = probe_r;
                CPS_OFS_PHY_IN:     rdata_nxt[CPS_PHY_IN_W-1:0] = phy_s;
                CPS_OFS_IRQ_STATUS: rdata_nxt[CPS_IRQ_W-1:0] = irq_status;
                CPS_OFS_IRQ_ENABLE: rdata_nxt[CPS_IRQ_W-1:0] = irq_enable;
                default:            rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    // ------------
    // outputs
    // ------------
    assign reg_rdata_o          = rdata_r;
    assign irq_o                = irq;
    assign mezz_power_allow_o   = allow_r; // R6
    assign mezz_power_allow_n_o = ~allow_r; // R7
    assign spare_link_o         = spare_r; // R1
    assign spare_link_oe_o      = {CPS_SPARE_W{spare_oe_r}}; // R2
    assign fanout_eq_enable_o   = eq_r; // R11
    assign panel_led_out_o      = led_r; // R13
    // probe 0 shows power permission, probe 1 the interrupt line
    assign scope_probe_out_o    = probe_r & {irq, allow_r}; // R14
    assign phy_txd_o            = '0; // R15
    assign phy_tx_en_o          = '0; // R15
    assign phy_gtx_clk_o        = '0; // R15
    assign phy_mdc_o            = '0; // R15
    assign phy_mdio_o           = '0; // R16
    assign phy_mdio_oe_o        = '0; // R16

endmodule // cps_top
`default_nettype wire

/* File: dv/cps_top_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module cps_top_properties
    import cps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic mezz_present_n_i,
    input wire logic mezz_supplies_ok_i,
    input wire logic mezz_power_allow_o,
    input wire logic mezz_power_allow_n_o,
    input wire logic [CPS_SPARE_W-1:0] spare_link_oe_o,
    input wire logic [CPS_EQ_W-1:0] fanout_eq_enable_o,
    input wire logic [CPS_LED_W-1:0] panel_led_out_o,
    input wire logic [CPS_PROBE_W-1:0] scope_probe_out_o,
    input wire logic [4*CPS_NUM_PHY-1:0] phy_txd_o,
    input wire logic [CPS_NUM_PHY-1:0] phy_tx_en_o,
    input wire logic [CPS_NUM_PHY-1:0] phy_gtx_clk_o,
    input wire logic [CPS_NUM_PHY-1:0] phy_mdc_o,
    input wire logic [CPS_NUM_PHY-1:0] phy_mdio_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    allow_pair_a: assert property (mezz_power_allow_n_o == !mezz_power_allow_o)
        else $error("allow pair not complementary");
    spare_hiz_a: assert property (!mezz_supplies_ok_i [*5] |-> spare_link_oe_o == '0)
        else $error("spare driven without good supplies");
    phy_quiet_a: assert property ((phy_txd_o | phy_tx_en_o | phy_gtx_clk_o) == '0
        && (phy_mdc_o | phy_mdio_oe_o) == '0) else $error("phy pin driven");
    absent_off_a: assert property (mezz_present_n_i [*5] |-> !mezz_power_allow_o)
        else $error("power granted with no mezzanine");
    eq_hold_a: assert property (!$stable(fanout_eq_enable_o) |-> $past(reg_wr_i)
        && $past(reg_addr_i) == CPS_OFS_FANOUT_EQ) else $error("eq changed without write");
    led_write_a: assert property (reg_wr_i && reg_addr_i == CPS_OFS_LED
        |=> panel_led_out_o == $past(reg_wdata_i[2:0])) else $error("led write lost");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read cycle");
    probe_off_a: assert property (!mezz_power_allow_o && !$past(mezz_power_allow_o)
        |-> !scope_probe_out_o[0]) else $error("probe active without use");
    power_up_c: cover property ($rose(mezz_power_allow_o));
    spare_on_c: cover property (spare_link_oe_o != '0);
    irq_on_c: cover property (irq_o);
endmodule // cps_top_properties
bind cps_top cps_top_properties u_props (.*);
`default_nettype wire

/* File: dv/cps_mezz_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cps_mezz_model
#(
    parameter int DLY = 4
)
(
    input  wire logic clk_i,
    input  wire logic fitted_i,
    input  wire logic stall_i,
    input  wire logic alert_i,
    input  wire logic allow_i,
    input  wire logic allow_n_i,
    output logic      present_n_o,
    output logic      supplies_ok_o,
    output logic      ready_o,
    output logic      spare_ctrl_o,
    output logic      alert_n_o
);
    int on_cnt = 0;
    // supplies ramp only while both halves of the pair grant power
    always @(posedge clk_i)
        on_cnt <= (allow_i && !allow_n_i && fitted_i && !stall_i) ? on_cnt + 1 : 0;
    assign present_n_o   = !fitted_i;
    assign supplies_ok_o = on_cnt >= DLY;
    assign ready_o       = on_cnt >= 2 * DLY;
    assign spare_ctrl_o  = 1'b1;
    assign alert_n_o     = !alert_i;
endmodule // cps_mezz_model
`default_nettype wire

/* File: dv/cps_top_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cps_top_bench
    import cps_pkg::*;
;
    logic clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, irq_o;
    logic [7:0] reg_addr_i = '0, spare, soe, txd;
    logic [31:0] reg_wdata_i = '0, reg_rdata_o, rd_q;
    logic pn, sok, rdy, sct, man, alw, alw_n, fitted = 0, stall = 0, alert = 0;
    logic b_alert_n = 1, b_pok = 1;
    logic [12:0] eq;
    logic [2:0] led;
    logic [1:0] prb, ten, gtx, mdc, mdo, moe;
    logic [17:0] phy_in = 18'h2A5C3;
    int fails = 0, num_checks = 0, i;
    always #5 clk_i = ~clk_i;
    cps_mezz_model #(.DLY(4)) mezz (.clk_i(clk_i), .fitted_i(fitted), .stall_i(stall),
        .alert_i(alert), .allow_i(alw), .allow_n_i(alw_n), .present_n_o(pn),
        .supplies_ok_o(sok), .ready_o(rdy), .spare_ctrl_o(sct), .alert_n_o(man));
    cps_top #(.RAMP_CYCLES(200)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
        .mezz_present_n_i(pn), .mezz_supplies_ok_i(sok), .mezz_ready_i(rdy),
        .mezz_spare_ctrl_i(sct), .mezz_supply_alert_n_i(man), .mezz_power_allow_o(alw),
        .mezz_power_allow_n_o(alw_n), .spare_link_o(spare), .spare_link_oe_o(soe),
        .board_supply_alert_n_i(b_alert_n), .board_power_ok_i(b_pok),
        .fanout_eq_enable_o(eq), .panel_led_out_o(led), .scope_probe_out_o(prb),
        .phy_txd_o(txd), .phy_tx_en_o(ten), .phy_gtx_clk_o(gtx), .phy_mdc_o(mdc),
        .phy_mdio_o(mdo), .phy_mdio_oe_o(moe), .phy_rxd_i(phy_in[7:0]),
        .phy_rx_clk_i(phy_in[9:8]), .phy_rx_dv_i(phy_in[11:10]),
        .phy_clk125_i(phy_in[13:12]), .phy_mdio_i(phy_in[15:14]), .phy_int_n_i(phy_in[17:16]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_q = reg_rdata_o;
    endtask
    task automatic t_reset;
        chk({alw, alw_n, soe, eq}, {2'h1, 8'h00, 13'h1FFF}, "reset outputs");
        chk({led, prb, txd, ten, gtx, mdc, mdo, moe}, '0, "quiet outputs");
        rd(CPS_OFS_PHY_IN);
        chk(rd_q, {14'h0000, phy_in}, "phy inputs");
        rd(8'hFC);
        chk(rd_q, '0, "unmapped read");
    endtask
    task automatic t_power;
        wr(CPS_OFS_SPARE_OUT, 32'h000000C3);
        fitted <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 chk(alw, 1'b0, "grant without enable");
        wr(CPS_OFS_CTRL, 32'h00000003);
        for (i = 0; i < 30 && soe !== 8'hFF; i++) @(posedge clk_i);
        #1 chk({alw, soe, spare}, {1'h1, 8'hFF, 8'hC3}, "spare drive");
        repeat (8) @(posedge clk_i);
        rd(CPS_OFS_STATUS);
        chk(rd_q[13:0] & 14'h3307, 14'h2307, "status on");
        stall <= 1'b1;
        for (i = 0; i < 20 && soe !== 8'h00; i++) @(posedge clk_i);
        #1 chk({alw, soe}, 9'h100, "supply loss");
        fitted <= 1'b0;
        for (i = 0; i < 20 && alw !== 1'b0; i++) @(posedge clk_i);
        #1 chk({alw, alw_n}, 2'h1, "removal");
        stall <= 1'b0;
        wr(CPS_OFS_CTRL, '0);
    endtask
    task automatic t_trip;
        fitted <= 1'b1;
        wr(CPS_OFS_CTRL, 32'h00000005);
        for (i = 0; i < 10 && alw !== 1'b1; i++) @(posedge clk_i);
        alert <= 1'b1;
        for (i = 0; i < 20 && alw !== 1'b0; i++) @(posedge clk_i);
        rd(CPS_OFS_STATUS);
        chk({alw, rd_q[13:12], rd_q[4]}, 4'h7, "alert trip");
        wr(CPS_OFS_CTRL, '0);
        alert <= 1'b0;
        fitted <= 1'b0;
    endtask
    task automatic t_irq;
        wr(CPS_OFS_IRQ_CLEAR, 32'h000000FF);
        wr(CPS_OFS_IRQ_ENABLE, 32'h00000030);
        b_alert_n <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1 chk(irq_o, 1'b1, "board alert irq");
        wr(CPS_OFS_IRQ_ENABLE, 32'h00000020);
        #1 chk(irq_o, 1'b0, "irq masked");
        b_pok <= 1'b0;
        repeat (5) @(posedge clk_i);
        #1 chk(irq_o, 1'b1, "power fault irq");
        wr(CPS_OFS_PROBE, 32'h00000003);
        #1 chk(prb, 2'h2, "probe irq");
        rd(CPS_OFS_IRQ_STATUS);
        chk(rd_q[5:4], 2'h3, "sticky status");
        b_alert_n <= 1'b1;
        b_pok <= 1'b1;
        wr(CPS_OFS_IRQ_CLEAR, 32'h00000030);
        #1 chk(irq_o, 1'b0, "irq cleared");
    endtask
    task automatic t_eq;
        wr(CPS_OFS_FANOUT_EQ, 32'h00000A5A);
        wr(CPS_OFS_LED, 32'h00000005);
        wr(CPS_OFS_PROBE, 32'h00000003);
        #1 chk({eq, led, prb}, {13'h0A5A, 3'h5, 2'h0}, "eq led probe");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        t_reset;
        t_power;
        t_trip;
        t_irq;
        t_eq;
        test_done;
    end
    initial
    begin
        #50000;
        fails++;
        test_done;
    end
endmodule // cps_top_bench
`default_nettype wire
